// ==== src/cuc_counter.sv ====
// module: bidirectional cascadable counter plus 27-bit three-stage up counter
// Function
// R1 - select 00 clears the count on the next edge, enables ignored
// R2 - select 01 with only up enable increments; no enable holds
// R3 - select 01 with only down enable decrements; both enables hold
// R4 - select 10 loads parallel data; select 11 holds; enables ignored
// R5 - each stage has eight bits plus a registered down-carry lookahead
// R6 - each stage gives up and down serial carries enabling the next stage
// R7 - stage enables formed in parallel as wide ANDs, not rippled
// R8 - longest path, first stage carry to last enable, fixed with length
// R9 - 27-bit loadable up counter split into three nine-bit stages
// R10 - second nine-bit stage counts when enabled and first stage all ones
// R11 - third nine-bit stage counts when enabled and lower stages all ones
// R12 - stage gives up terminal count all ones, down terminal count all zeros
// R13 - down terminal count registered, set on the edge reaching zero
// R14 - on load, down terminal count flag set from loaded value
// R15 - load forces current-count feedback low; data alone sets next value
// R16 - several selectable load sources, one load term each
// R17 - all state changes on rising edge of one clock only; the code also loads its reset values asynchronously on rising rst
// R18 - counting wraps modulo two to the width
// R19 - surrounding logic keeps inputs synchronous and wires carries onward
`default_nettype none
module cuc_counter
    import cuc_pkg::*;
(
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // bidirectional counter controls
    input  wire cuc_ctrl_t                 ctrl,
    input  wire logic [CUC_NSRC-1:0]       load_src_sel,
    input  wire logic [CUC_BIDIR_W-1:0]    load_data_a,
    input  wire logic [CUC_BIDIR_W-1:0]    load_data_b,
    // unidirectional counter controls
    input  wire logic                      uni_load,
    input  wire logic                      uni_count,
    input  wire logic [CUC_UNI_TOT-1:0]    uni_data,
    // outputs
    output logic [CUC_BIDIR_W-1:0]         count_q,
    output logic [CUC_NSTAGE-1:0]          down_carry_lookahead_reg,
    output cuc_carry_t                     carry_q,
    output logic [CUC_UNI_TOT-1:0]         uni_count_q,
    output logic                           stage_two_enable,
    output logic                           stage_three_enable
);
    // ------------------------------------------------------------
    // bidirectional counter
    // ------------------------------------------------------------
    logic [CUC_BIDIR_W-1:0] count_d;
    logic [CUC_NSTAGE-1:0]  dtc_d;
    cuc_carry_t             carry_d;
    logic [CUC_NSTAGE-1:0]  uptc;
    logic [CUC_NSTAGE-1:0]  dtc_next;
    logic [CUC_NSTAGE-1:0]  up_en;
    logic [CUC_NSTAGE-1:0]  dn_en;
    logic [CUC_BIDIR_W-1:0] load_val;
    logic                   is_load;
    logic                   go_up;
    logic                   go_dn;
    logic [CUC_NSTAGE-1:0]  uptc_nx;
    logic [CUC_NSTAGE-1:0]  up_carry_nx;
    logic [CUC_NSTAGE-1:0]  dn_carry_nx;

    assign is_load = (ctrl.func_sel == CUC_SEL_LD);
    assign go_up   = (ctrl.func_sel == CUC_SEL_CNT) && ctrl.up_count_enable
                     && !ctrl.down_count_enable;
    assign go_dn   = (ctrl.func_sel == CUC_SEL_CNT) && !ctrl.up_count_enable
                     && ctrl.down_count_enable;

    always_comb begin
        // one load term per source, or-combined
        load_val = '0;
        if (load_src_sel[0]) begin
            load_val = load_val | load_data_a; // R16
        end
        if (load_src_sel[1]) begin
            load_val = load_val | load_data_b; // R16
        end
    end

    genvar gs;
    generate
        for (gs = 0; gs < CUC_NSTAGE; gs++) begin : g_stage
            logic [CUC_STAGE_W-1:0] seg;
            logic [CUC_STAGE_W-1:0] fb;
            logic [CUC_STAGE_W-1:0] ld;
            assign seg = count_q[gs*CUC_STAGE_W +: CUC_STAGE_W];
            assign ld  = load_val[gs*CUC_STAGE_W +: CUC_STAGE_W];
            assign fb  = seg & {CUC_STAGE_W{!is_load}}; // R15
            assign uptc[gs] = &seg; // R12
            // wide and of all lower terminal counts, no ripple
            if (gs == 0) begin : g_first
                assign up_en[gs] = go_up; // R7
                assign dn_en[gs] = go_dn; // R7
            end else begin : g_rest
                assign up_en[gs] = go_up && (&uptc[gs-1:0]); // R7 R8
                assign dn_en[gs] = go_dn && (&down_carry_lookahead_reg[gs-1:0]); // R7 R8
            end
            always_comb begin
                if (ctrl.func_sel == CUC_SEL_CLR) begin
                    count_d[gs*CUC_STAGE_W +: CUC_STAGE_W] = '0; // R1
                    dtc_next[gs] = 1'b1;
                end else if (is_load) begin
                    count_d[gs*CUC_STAGE_W +: CUC_STAGE_W] = fb | ld; // R4 R15
                    dtc_next[gs] = (ld == '0); // R14
                end else if (up_en[gs]) begin
                    count_d[gs*CUC_STAGE_W +: CUC_STAGE_W] = fb + 8'h01; // R2 R18
                    dtc_next[gs] = (fb == 8'hff);
                end else if (dn_en[gs]) begin
                    count_d[gs*CUC_STAGE_W +: CUC_STAGE_W] = fb - 8'h01; // R3 R18
                    dtc_next[gs] = (fb == 8'h01); // R13
                end else begin
                    count_d[gs*CUC_STAGE_W +: CUC_STAGE_W] = fb; // R3 R4
                    dtc_next[gs] = down_carry_lookahead_reg[gs];
                end
                dtc_d[gs] = dtc_next[gs]; // R5 R13
            end
            // carries: this stage and all below at terminal count after the edge
            assign up_carry_nx[gs] = &uptc_nx[gs:0]; // R6 R7
            assign dn_carry_nx[gs] = &dtc_d[gs:0]; // R6 R7
        end
    endgenerate

    // next-cycle up terminal counts for registered carry outputs
    always_comb begin
        for (int i = 0; i < CUC_NSTAGE; i++) begin
            uptc_nx[i] = &count_d[i*CUC_STAGE_W +: CUC_STAGE_W];
        end
    end

    always_comb begin
        carry_d.serial_carry_up_out   = up_carry_nx; // R6
        carry_d.serial_carry_down_out = dn_carry_nx; // R6
    end

    always_ff @(posedge sys_clk or posedge rst) begin // R17
        if (rst) begin
            count_q                  <= CUC_BIDIR_RST;
            down_carry_lookahead_reg <= CUC_DTC_RST;
            carry_q                  <= '0;
        end else begin
            count_q                  <= count_d;
            down_carry_lookahead_reg <= dtc_d;
            carry_q                  <= carry_d;
        end
    end

    // ------------------------------------------------------------
    // unidirectional 27-bit up counter
    // ------------------------------------------------------------
    logic [CUC_UNI_TOT-1:0] uni_d;
    logic [CUC_UNI_N-1:0]   uni_en;
    logic [CUC_UNI_N-1:0]   uni_full;
    logic                   en2_d;
    logic                   en3_d;

    genvar gu;
    generate
        for (gu = 0; gu < CUC_UNI_N; gu++) begin : g_uni // R9
            logic [CUC_UNI_W-1:0] useg;
            logic [CUC_UNI_W-1:0] ufb;
            assign useg = uni_count_q[gu*CUC_UNI_W +: CUC_UNI_W];
            assign ufb  = useg & {CUC_UNI_W{!uni_load}}; // R15
            assign uni_full[gu] = &useg;
            if (gu == 0) begin : g_u0
                assign uni_en[gu] = uni_count;
            end else begin : g_un
                assign uni_en[gu] = uni_count && (&uni_full[gu-1:0]); // R10 R11
            end
            always_comb begin
                if (uni_load) begin
                    uni_d[gu*CUC_UNI_W +: CUC_UNI_W] = ufb | uni_data[gu*CUC_UNI_W +: CUC_UNI_W];
                end else if (uni_en[gu]) begin
                    uni_d[gu*CUC_UNI_W +: CUC_UNI_W] = ufb + 9'h001; // R9 R18
                end else begin
                    uni_d[gu*CUC_UNI_W +: CUC_UNI_W] = ufb;
                end
            end
        end
    endgenerate

    always_comb begin
        en2_d = uni_count && (&uni_d[CUC_UNI_W-1:0]); // R10
        en3_d = uni_count && (&uni_d[2*CUC_UNI_W-1:0]); // R11
    end

    always_ff @(posedge sys_clk or posedge rst) begin // R17
        if (rst) begin
            uni_count_q        <= CUC_UNI_RST;
            stage_two_enable   <= 1'b0;
            stage_three_enable <= 1'b0;
        end else begin
            uni_count_q        <= uni_d;
            stage_two_enable   <= en2_d;
            stage_three_enable <= en3_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_clear_zero: assert property (ctrl.func_sel == CUC_SEL_CLR |=> count_q == '0) // R1
        else $error("clear did not zero count");
    a_count_up_step: assert property (go_up |=> count_q == $past(count_q) + 16'h0001) // R2 R18
        else $error("up count wrong");
    a_count_dn_step: assert property (go_dn |=> count_q == $past(count_q) - 16'h0001) // R3 R18
        else $error("down count wrong");
    a_hold_both: assert property ((ctrl.func_sel == CUC_SEL_HOLD) || ((ctrl.func_sel
        == CUC_SEL_CNT) && (ctrl.up_count_enable == ctrl.down_count_enable))
        |=> $stable(count_q)) // R3 R4
        else $error("hold changed count");
    a_load_value: assert property (is_load |=> count_q == $past(load_val)) // R4 R15
        else $error("load value wrong");
    a_dtc_tracks: assert property (##1 down_carry_lookahead_reg[0] == (count_q[7:0] == 8'h00)) // R13 R14
        else $error("down terminal count flag mismatch");
    a_uni_wrap: assert property (uni_count && !uni_load && (&uni_count_q)
        |=> uni_count_q == '0) // R11 R18
        else $error("uni counter did not wrap");
    a_stage_two: assert property (stage_two_enable == (uni_count_q[8:0] == 9'h1ff)
        || !$past(uni_count)) // R10
        else $error("stage two enable mismatch");
    a_stage_three: assert property (stage_three_enable == (uni_count_q[17:0] == 18'h3ffff)
        || !$past(uni_count)) // R11
        else $error("stage three enable mismatch");

    c_up_wrap: cover property (go_up && count_q == 16'hffff);
    c_dn_wrap: cover property (go_dn && count_q == 16'h0000);
    c_load_zero: cover property (is_load && load_val == '0);
    c_uni_stage3: cover property (stage_three_enable);
endmodule : cuc_counter
`default_nettype wire

// ==== src/cuc_pkg.sv ====
// package: constants and carrier types for the cascadable up/down counter
`default_nettype none
package cuc_pkg;
    // ------------------------------------------------------------
    // widths and encodings
    // ------------------------------------------------------------
    localparam int          CUC_STAGE_W  = 8;
    localparam int          CUC_NSTAGE   = 2;
    localparam int          CUC_BIDIR_W  = CUC_STAGE_W * CUC_NSTAGE;
    localparam int          CUC_UNI_W    = 9;
    localparam int          CUC_UNI_N    = 3;
    localparam int          CUC_UNI_TOT  = CUC_UNI_W * CUC_UNI_N;
    localparam int          CUC_NSRC     = 2;
    localparam logic [1:0]  CUC_SEL_CLR  = 2'h0;
    localparam logic [1:0]  CUC_SEL_CNT  = 2'h1;
    localparam logic [1:0]  CUC_SEL_LD   = 2'h2;
    localparam logic [1:0]  CUC_SEL_HOLD = 2'h3;
    localparam logic [CUC_BIDIR_W-1:0] CUC_BIDIR_RST = 16'h0000;
    localparam logic [CUC_UNI_TOT-1:0] CUC_UNI_RST   = 27'h0000000;
    localparam logic [CUC_NSTAGE-1:0]  CUC_DTC_RST   = 2'h3;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] func_sel;
        logic       up_count_enable;
        logic       down_count_enable;
    } cuc_ctrl_t;

    typedef struct packed {
        logic [CUC_NSTAGE-1:0] serial_carry_up_out;
        logic [CUC_NSTAGE-1:0] serial_carry_down_out;
    } cuc_carry_t;
endpackage : cuc_pkg
`default_nettype wire

// ==== tb/cascadable_updown_counter_tb.sv ====
// testbench: directed scenarios for the cascadable up/down counter
`default_nettype none
module cascadable_updown_counter_tb
    import cuc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   sys_clk = 1'b0;
    logic                   rst = 1'b1;
    cuc_ctrl_t              ctrl = 4'h0;
    logic [1:0]             load_src_sel = 2'h0;
    logic [15:0]            load_data_a = 16'h0000;
    logic [15:0]            load_data_b = 16'h0000;
    logic                   uni_load = 1'b0;
    logic                   uni_count = 1'b0;
    logic [26:0]            uni_data = 27'h0;
    logic [15:0]            count_q;
    logic [1:0]             down_carry_lookahead_reg;
    cuc_carry_t             carry_q;
    logic [26:0]            uni_count_q;
    logic                   stage_two_enable;
    logic                   stage_three_enable;
    logic [7:0]             ext_q;
    int                     n_mismatch = 0;
    int                     checks = 0;

    always #4 sys_clk = ~sys_clk;

    cuc_counter uut (.sys_clk, .rst, .ctrl, .load_src_sel, .load_data_a, .load_data_b,
        .uni_load, .uni_count, .uni_data, .count_q, .down_carry_lookahead_reg, .carry_q,
        .uni_count_q, .stage_two_enable, .stage_three_enable);
    cuc_ext_stage ext (.sys_clk, .rst, .ctrl, .carry_q, .ext_q);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task tick();
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : tick

    task give_verdict();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_load_down();
        load_data_a = 16'h0001; load_src_sel = 2'h1; ctrl = {CUC_SEL_LD, 2'h3}; tick();
        chk(count_q, 16'h0001);
        chk(down_carry_lookahead_reg, 2'h2);
        ctrl = {CUC_SEL_CNT, 2'h1}; tick();
        chk(count_q, 16'h0000);
        chk(down_carry_lookahead_reg, 2'h3);
        chk(carry_q.serial_carry_down_out, 2'h3);
        tick();
        chk(count_q, 16'hffff);
        chk(down_carry_lookahead_reg, 2'h0);
        chk(ext_q, 8'hff);
        ctrl = {CUC_SEL_CNT, 2'h3}; tick();
        chk(count_q, 16'hffff);
        $display("test load_down done");
    endtask : t_load_down

    task t_up_clear();
        ctrl = {CUC_SEL_CNT, 2'h0}; tick();
        chk(count_q, 16'hffff);
        chk(carry_q.serial_carry_up_out, 2'h3);
        ctrl = {CUC_SEL_CNT, 2'h2}; tick();
        chk(count_q, 16'h0000);
        chk(ext_q, 8'h00);
        tick();
        chk(count_q, 16'h0001);
        chk(carry_q, 4'h0);
        ctrl = {CUC_SEL_HOLD, 2'h2}; tick();
        chk(count_q, 16'h0001);
        ctrl = {CUC_SEL_CLR, 2'h3}; tick();
        chk(count_q, 16'h0000);
        chk(down_carry_lookahead_reg, 2'h3);
        $display("test up_clear done");
    endtask : t_up_clear

    task t_sources();
        load_data_a = 16'h00f0; load_data_b = 16'h0f00; load_src_sel = 2'h3;
        ctrl = {CUC_SEL_LD, 2'h2}; tick();
        chk(count_q, 16'h0ff0);
        load_src_sel = 2'h2; tick();
        chk(count_q, 16'h0f00);
        load_src_sel = 2'h0; tick();
        chk(count_q, 16'h0000);
        chk(down_carry_lookahead_reg, 2'h3);
        $display("test sources done");
    endtask : t_sources

    task t_uni();
        uni_data = 27'h1fe; uni_load = 1'b1; uni_count = 1'b1; tick();
        chk(uni_count_q, 27'h1fe);
        uni_load = 1'b0; tick();
        chk(uni_count_q, 27'h1ff);
        chk(stage_two_enable, 1'b1);
        chk(stage_three_enable, 1'b0);
        tick();
        chk(uni_count_q, 27'h200);
        uni_data = 27'h3fffe; uni_load = 1'b1; tick();
        uni_load = 1'b0; tick();
        chk(stage_three_enable, 1'b1);
        uni_count = 1'b0; tick();
        chk(uni_count_q, 27'h3ffff);
        chk(stage_two_enable, 1'b0);
        uni_count = 1'b1; tick();
        chk(uni_count_q, 27'h40000);
        uni_data = 27'h7ffffff;
        uni_load = 1'b1;
        tick();
        chk(stage_three_enable, 1'b1);
        uni_load = 1'b0;
        tick();
        chk(uni_count_q, 27'h0000000);
        chk(stage_two_enable, 1'b0);
        $display("test uni done");
    endtask : t_uni

    task t_reset();
        load_data_a = 16'h1234;
        load_src_sel = 2'h1;
        ctrl = {CUC_SEL_LD, 2'h0};
        tick();
        chk(count_q, 16'h1234);
        rst = 1'b1;
        tick();
        chk(count_q, 16'h0000);
        chk(down_carry_lookahead_reg, 2'h3);
        chk(carry_q, 4'h0);
        chk(uni_count_q, 27'h0000000);
        chk(stage_three_enable, 1'b0);
        chk(ext_q, 8'h00);
        rst = 1'b0;
        ctrl = {CUC_SEL_CNT, 2'h2};
        tick();
        chk(count_q, 16'h0001);
        $display("test reset done");
    endtask : t_reset

    initial begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(down_carry_lookahead_reg, 2'h3);
        rst = 1'b0;
        t_load_down();
        t_up_clear();
        t_sources();
        t_uni();
        t_reset();
        give_verdict();
    end
endmodule : cascadable_updown_counter_tb
`default_nettype wire

// ==== tb/cuc_ext_stage.sv ====
// partner: next more significant stage cascaded from the counter carries
`default_nettype none
module cuc_ext_stage
    import cuc_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // controls and carries seen from the counter
    input  wire cuc_ctrl_t  ctrl,
    input  wire cuc_carry_t carry_q,
    // extension count
    output logic [7:0]      ext_q
);
    logic [7:0] ext_d;
    logic       up_only;
    logic       dn_only;

    // ------------------------------------------------------------
    // next state from the top stage carries
    // ------------------------------------------------------------
    always_comb begin
        up_only = ctrl.up_count_enable && !ctrl.down_count_enable;
        dn_only = ctrl.down_count_enable && !ctrl.up_count_enable;
        ext_d   = ext_q;
        if (ctrl.func_sel == CUC_SEL_CLR || ctrl.func_sel == CUC_SEL_LD) begin
            ext_d = 8'h00;
        end else if (ctrl.func_sel == CUC_SEL_CNT) begin
            if (up_only && carry_q.serial_carry_up_out[CUC_NSTAGE-1]) begin
                ext_d = ext_q + 8'h01;
            end else if (dn_only && carry_q.serial_carry_down_out[CUC_NSTAGE-1]) begin
                ext_d = ext_q - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_q <= 8'h00;
        end else begin
            ext_q <= ext_d;
        end
    end
endmodule : cuc_ext_stage
`default_nettype wire
